// >>> ssac_pkg.sv
// Package for the single-slope converter control block.
// Assumes an AHB-Lite master with 32-bit word accesses; one register per word.
package ssac_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] ANALOG_CONTROL_IDX = 6'h1D;
  localparam logic [5:0] STATUS_IDX         = 6'h1E;
  localparam logic [5:0] CHANNEL_IDX        = 6'h1F;
  localparam logic [5:0] REFERENCE_IDX      = 6'h20;
  localparam logic [5:0] MISC_IDX           = 6'h0B;
  localparam logic [5:0] CAPTURE_HIGH_IDX   = 6'h14;
  localparam logic [5:0] CAPTURE_LOW_IDX    = 6'h15;

  // Field positions in the status, reference and misc registers, plus the control register's upper mode bit
  localparam int FLAG_BIT         = 7;
  localparam int FLAG_CLEAR_BIT   = 6;
  localparam int SUPPLY_REF_BIT   = 1;
  localparam int BIAS_REF_BIT     = 0;
  localparam int CAPTURE_SRC_BIT  = 2;
  localparam int MODE_HIGH_BIT    = 6;

  // Reset values
  localparam logic [7:0] ANALOG_CONTROL_RST = 8'h00;
  localparam logic [7:0] CHANNEL_RST        = 8'h00;
  localparam logic [1:0] REFERENCE_RST      = 2'h0;
  localparam logic [15:0] CAPTURE_RST       = 16'h0000;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SSAC_MODE_MANUAL      = 2'b00,
    SSAC_MODE_AUTO_DISCH  = 2'b01,
    SSAC_MODE_OVERFLOW    = 2'b10,
    SSAC_MODE_COMPARE     = 2'b11
  } ssac_mode_t;

  typedef struct packed {
    logic       charge_select;
    ssac_mode_t conversion_mode;
    logic       capture_from_comparator;
    logic       comparator_irq_enable;
    logic       spare;
    logic       comparator_power_enable;
    logic       current_source_enable;
  } ssac_ctrl_t;

endpackage : ssac_pkg

// >>> ssac_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the levels are slow against hclk; no pulse is stretched here.
`timescale 1ns/1ps
`default_nettype none
module ssac_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("ssac_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule : ssac_sync
`default_nettype wire

// >>> ssac_top.sv
// Single-slope converter control: switch matrix, ramp control, flag, capture routing.
// Assumes an AHB-Lite master, a timer on hclk giving event pulses and a count,
// and analog pins (comparator output, capture pin, serial clock) from outside.
// What this block does
// - each channel bit connects its analog input to the bus, else high impedance
// - with no channel bits, supply or bias reference alone connects to the bus
// - control register at index 1D, cleared on reset, analog parts powered down
// - charge select forced clear when source disabled; reads show discharge state
// - writing one to charge select sources current if source enabled
// - writing zero to charge select stops charging and starts discharging
// - two mode bits pick four modes, ignored when source disabled, reset manual
// - source disabled means neither sourcing nor sinking at the ramp pin
// - mode 0 sources when charge select set, sinks when clear, software only
// - mode 1 also clears charge select when comparator flag becomes set
// - mode 2 starts sourcing at next timer overflow while sinking
// - mode 3 starts sourcing at next timer compare while sinking
// - modes 2 and 3 start sinking at next timer capture while sourcing
// - in timer modes charge select changes on designated timer events and on software writes
// - capture routing set takes trigger from flag, clear from capture pin
// - capture routing set by hardware when upper mode bit written, resets zero
// - comparator capture latches timer count into 16-bit capture buffer
// - capture source select bit 2 picks serial clock line regardless of routing
// - comparator flag set and held once positive input exceeds negative
// - writing one to flag clear clears flag; zero ignored; reads as zero
// - clearing source enable disables source and discharge at once
// - irq enable gates interrupt request from comparator flag, resets zero
`timescale 1ns/1ps
`default_nettype none
module ssac_top #(
  parameter int CHANNELS = 8
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output var  logic [31:0]         hrdata,
  output var  logic                hreadyout,
  output var  logic                hresp,
  input  wire logic                comparator_out,
  input  wire logic                external_capture_pin,
  input  wire logic                serial_clock_line,
  input  wire logic                timer_overflow_event,
  input  wire logic                timer_compare_event,
  input  wire logic                timer_capture_event,
  input  wire logic [15:0]         timer_count,
  output var  logic [CHANNELS-1:0] channel_connect,
  output var  logic                supply_ref_connect,
  output var  logic                bias_ref_connect,
  output var  logic                ramp_source_on,
  output var  logic                ramp_sink_on,
  output var  logic                comparator_power,
  output var  logic                capture_trigger,
  output var  logic                comparator_irq
);

  ssac_pkg::ssac_ctrl_t  ctrl;
  ssac_pkg::ssac_ctrl_t  next_ctrl;
  logic [CHANNELS-1:0]   channel_switch;
  logic [1:0]            reference_select;
  logic                  capture_source_select;
  logic                  comparator_flag;
  logic                  next_comparator_flag;
  logic                  flag_prev;
  logic [15:0]           capture_time;
  logic                  trigger_prev;
  logic                  overflow_prev;
  logic                  compare_prev;
  logic                  capture_prev;
  logic                  overflow_pulse;
  logic                  compare_pulse;
  logic                  capture_pulse;
  logic [2:0]            pins_sync;
  logic                  comparator_sync;
  logic                  capture_pin_sync;
  logic                  serial_clock_sync;
  logic                  dp_valid;
  logic                  dp_write;
  logic [5:0]            dp_index;
  logic                  rd_pending;
  logic                  addr_accept;
  logic                  addr_mapped;
  logic                  wr_ctrl;
  logic                  wr_status;
  logic                  wr_channel;
  logic                  wr_reference;
  logic                  wr_misc;
  logic [7:0]            read_value;

  if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
    $error("ssac_top: CHANNELS must be 1 to 8");
  end

  // Pins are asynchronous to hclk
  ssac_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({serial_clock_line, external_capture_pin, comparator_out}),
    .sync_out (pins_sync)
  );

  assign comparator_sync   = pins_sync[0];
  assign capture_pin_sync  = pins_sync[1];
  assign serial_clock_sync = pins_sync[2];

  // AHB-Lite address phase
  assign addr_accept = hsel && htrans[1] && hready;
  assign addr_mapped = (haddr[31:8] == 24'h000000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_index <= 6'h00;
    end else if (hready) begin
      dp_valid <= addr_accept && addr_mapped;
      dp_write <= addr_accept && hwrite;
      dp_index <= haddr[7:2];
    end
  end

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pending <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h00000000;
      hresp      <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (addr_accept && !hwrite) begin
        rd_pending <= 1'b1;
        hreadyout  <= 1'b0;
      end else if (rd_pending) begin
        rd_pending <= 1'b0;
        hreadyout  <= 1'b1;
        hrdata     <= {24'h000000, read_value};
      end
    end
  end

  assign wr_ctrl      = dp_valid && dp_write && (dp_index == ssac_pkg::ANALOG_CONTROL_IDX);
  assign wr_status    = dp_valid && dp_write && (dp_index == ssac_pkg::STATUS_IDX);
  assign wr_channel   = dp_valid && dp_write && (dp_index == ssac_pkg::CHANNEL_IDX);
  assign wr_reference = dp_valid && dp_write && (dp_index == ssac_pkg::REFERENCE_IDX);
  assign wr_misc      = dp_valid && dp_write && (dp_index == ssac_pkg::MISC_IDX);

  // Unmapped reads return zero
  always_comb begin
    read_value = 8'h00;
    if (!dp_valid) begin
      read_value = 8'h00;
    end else if (dp_index == ssac_pkg::ANALOG_CONTROL_IDX) begin
      read_value = ctrl;
    end else if (dp_index == ssac_pkg::STATUS_IDX) begin
      read_value[ssac_pkg::FLAG_BIT] = comparator_flag;
    end else if (dp_index == ssac_pkg::CHANNEL_IDX) begin
      read_value[CHANNELS-1:0] = channel_switch;
    end else if (dp_index == ssac_pkg::REFERENCE_IDX) begin
      read_value[1:0] = reference_select;
    end else if (dp_index == ssac_pkg::MISC_IDX) begin
      read_value[ssac_pkg::CAPTURE_SRC_BIT] = capture_source_select;
    end else if (dp_index == ssac_pkg::CAPTURE_HIGH_IDX) begin
      read_value = capture_time[15:8];
    end else if (dp_index == ssac_pkg::CAPTURE_LOW_IDX) begin
      read_value = capture_time[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_prev <= 1'b0;
      compare_prev  <= 1'b0;
      capture_prev  <= 1'b0;
    end else begin
      overflow_prev <= timer_overflow_event;
      compare_prev  <= timer_compare_event;
      capture_prev  <= timer_capture_event;
    end
  end

  assign overflow_pulse = timer_overflow_event && !overflow_prev;
  assign compare_pulse  = timer_compare_event && !compare_prev;
  assign capture_pulse  = timer_capture_event && !capture_prev;

  // Comparator flag; a set in the clearing cycle wins
  always_comb begin
    next_comparator_flag = comparator_flag;
    if (wr_status && hwdata[ssac_pkg::FLAG_CLEAR_BIT]) begin
      next_comparator_flag = 1'b0;
    end
    if (comparator_sync) begin
      next_comparator_flag = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comparator_flag <= 1'b0;
      flag_prev       <= 1'b0;
    end else begin
      comparator_flag <= next_comparator_flag;
      flag_prev       <= comparator_flag;
    end
  end

  // Control register and hardware sequencing
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl       = ssac_pkg::ssac_ctrl_t'(hwdata[7:0]);
      next_ctrl.spare = 1'b0;
      if (hwdata[ssac_pkg::MODE_HIGH_BIT]) begin
        next_ctrl.capture_from_comparator = 1'b1;
      end
    end
    // mode has effect only when enabled
    if (next_ctrl.current_source_enable) begin
      case (next_ctrl.conversion_mode)
        ssac_pkg::SSAC_MODE_MANUAL: begin
          next_ctrl.charge_select = next_ctrl.charge_select;
        end
        ssac_pkg::SSAC_MODE_AUTO_DISCH: begin
          if (comparator_flag && !flag_prev) begin
            next_ctrl.charge_select = 1'b0;
          end
        end
        // overflow starts ramp; capture ends it; holds otherwise
        ssac_pkg::SSAC_MODE_OVERFLOW: begin
          if (!ctrl.charge_select && overflow_pulse) begin
            next_ctrl.charge_select = 1'b1;
          end else if (ctrl.charge_select && capture_pulse) begin
            next_ctrl.charge_select = 1'b0;
          end
        end
        // compare starts ramp; capture ends it; holds otherwise
        ssac_pkg::SSAC_MODE_COMPARE: begin
          if (!ctrl.charge_select && compare_pulse) begin
            next_ctrl.charge_select = 1'b1;
          end else if (ctrl.charge_select && capture_pulse) begin
            next_ctrl.charge_select = 1'b0;
          end
        end
        default: begin
          next_ctrl.charge_select = 1'b0;
        end
      endcase
    end else begin
      next_ctrl.charge_select = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= ssac_pkg::ssac_ctrl_t'(ssac_pkg::ANALOG_CONTROL_RST);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Switch matrix and reference selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_switch        <= ssac_pkg::CHANNEL_RST[CHANNELS-1:0];
      reference_select      <= ssac_pkg::REFERENCE_RST;
      capture_source_select <= 1'b0;
    end else begin
      if (wr_channel) begin
        channel_switch <= hwdata[CHANNELS-1:0];
      end
      if (wr_reference) begin
        reference_select <= hwdata[1:0];
      end
      if (wr_misc) begin
        capture_source_select <= hwdata[ssac_pkg::CAPTURE_SRC_BIT];
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_switch
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          channel_connect[ch] <= 1'b0;
        end else begin
          channel_connect[ch] <= channel_switch[ch];
        end
      end
    end
  endgenerate

  // reference only on idle bus, one alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_ref_connect <= 1'b0;
      bias_ref_connect   <= 1'b0;
    end else begin
      supply_ref_connect <= (channel_switch == '0)
                            && reference_select[ssac_pkg::SUPPLY_REF_BIT]
                            && !reference_select[ssac_pkg::BIAS_REF_BIT];
      bias_ref_connect   <= (channel_switch == '0)
                            && reference_select[ssac_pkg::BIAS_REF_BIT]
                            && !reference_select[ssac_pkg::SUPPLY_REF_BIT];
    end
  end

  // Ramp drive follows the stored register, one cycle behind
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ramp_source_on   <= 1'b0;
      ramp_sink_on     <= 1'b0;
      comparator_power <= 1'b0;
      comparator_irq   <= 1'b0;
    end else begin
      ramp_source_on   <= ctrl.current_source_enable && ctrl.charge_select;
      ramp_sink_on     <= ctrl.current_source_enable && !ctrl.charge_select;
      comparator_power <= ctrl.comparator_power_enable;
      comparator_irq   <= comparator_flag && ctrl.comparator_irq_enable;
    end
  end

  // Capture source selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capture_trigger <= 1'b0;
    end else if (capture_source_select) begin
      capture_trigger <= serial_clock_sync;
    end else if (ctrl.capture_from_comparator) begin
      capture_trigger <= comparator_flag;
    end else begin
      capture_trigger <= capture_pin_sync;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trigger_prev <= 1'b0;
      capture_time <= ssac_pkg::CAPTURE_RST;
    end else begin
      trigger_prev <= capture_trigger;
      if (capture_trigger && !trigger_prev) begin
        capture_time <= timer_count;
      end
    end
  end

endmodule : ssac_top
`default_nettype wire

// >>> ssac_top_asserts.sv
// Checker for the converter control block, bound to the top module.
// Assumes word writes on AHB-Lite; shadows control and misc writes from the bus.
`timescale 1ns/1ps
`default_nettype none
module ssac_top_checker #(
  parameter int CHANNELS = 8
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic                external_capture_pin,
  input wire logic                timer_overflow_event,
  input wire logic                timer_compare_event,
  input wire logic                timer_capture_event,
  input wire logic [CHANNELS-1:0] channel_connect,
  input wire logic                supply_ref_connect,
  input wire logic                bias_ref_connect,
  input wire logic                ramp_source_on,
  input wire logic                ramp_sink_on,
  input wire logic                capture_trigger,
  input wire logic                comparator_irq
);
  logic       wr_pend;
  logic [5:0] wr_idx;
  logic [7:0] sh;
  logic [7:0] sh_p;
  logic       misc;
  logic [3:0] pin_h;
  logic [2:0] sel_h;
  logic       sel_any;
  assign sel_any = sh[4] | sh[6] | misc;
  // Software view only; hardware changes of charge select are not tracked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 6'h00;
      sh      <= 8'h00;
      sh_p    <= 8'h00;
      misc    <= 1'b0;
      pin_h   <= 4'h0;
      sel_h   <= 3'h0;
    end else begin
      wr_pend <= hsel && htrans[1] && hready && hwrite && (haddr[31:8] == 24'h000000);
      wr_idx  <= haddr[7:2];
      sh_p    <= sh;
      pin_h   <= {pin_h[2:0], external_capture_pin};
      sel_h   <= {sel_h[1:0], sel_any};
      if (wr_pend && wr_idx == ssac_pkg::ANALOG_CONTROL_IDX) sh <= hwdata[7:0];
      if (wr_pend && wr_idx == ssac_pkg::MISC_IDX) misc <= hwdata[ssac_pkg::CAPTURE_SRC_BIT];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_drive_exclusive: assert property (
    !(ramp_source_on && ramp_sink_on)) else $error("ramp sources and sinks at once");
  a_ref_exclusive: assert property (
    (supply_ref_connect || bias_ref_connect) |-> channel_connect == '0
      && !(supply_ref_connect && bias_ref_connect)) else $error("reference joined wrongly");
  a_read_wait: assert property (
    (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_disabled_idle: assert property (
    (!sh[0] && !$past(sh[0]) && !$past(sh[0], 2)) |-> !ramp_source_on && !ramp_sink_on)
    else $error("ramp driven while source disabled");
  a_overflow_charge: assert property (
    (sh[0] && sh[6:5] == 2'b10 && sh == sh_p && ramp_sink_on && $rose(timer_overflow_event))
      |-> ##[1:3] ramp_source_on) else $error("overflow did not start charging");
  a_compare_charge: assert property (
    (sh[0] && sh[6:5] == 2'b11 && sh == sh_p && ramp_sink_on && $rose(timer_compare_event))
      |-> ##[1:3] ramp_source_on) else $error("compare did not start charging");
  a_capture_sink: assert property (
    (sh[0] && sh[6] && sh == sh_p && ramp_source_on && $rose(timer_capture_event))
      |-> ##[1:3] ramp_sink_on) else $error("capture did not start discharge");
  a_irq_gate: assert property (
    (!sh[3] && !$past(sh[3]) && !$past(sh[3], 2)) |-> !comparator_irq)
    else $error("interrupt while disabled");
  a_pin_route: assert property (
    (!sel_any && sel_h == 3'h0 && pin_h == {4{external_capture_pin}})
      |-> capture_trigger == external_capture_pin) else $error("capture pin not routed");
  c_overflow: cover property (sh[0] && ramp_sink_on && $rose(timer_overflow_event));
  c_irq: cover property ($rose(comparator_irq));
  c_misc: cover property (misc && $rose(capture_trigger));
endmodule : ssac_top_checker
bind ssac_top ssac_top_checker #(.CHANNELS(CHANNELS)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .external_capture_pin(external_capture_pin),
  .timer_overflow_event(timer_overflow_event), .timer_compare_event(timer_compare_event),
  .timer_capture_event(timer_capture_event), .channel_connect(channel_connect),
  .supply_ref_connect(supply_ref_connect), .bias_ref_connect(bias_ref_connect),
  .ramp_source_on(ramp_source_on), .ramp_sink_on(ramp_sink_on),
  .capture_trigger(capture_trigger), .comparator_irq(comparator_irq));
`default_nettype wire

// >>> ssac_far_side.sv
// Model of the timer, comparator and capture pins beyond the block.
// Assumes the bench calls its tasks; the timer count stands until set.
`timescale 1ns/1ps
`default_nettype none
module ssac_far_side (
  input  wire logic        hclk,
  output var  logic        comparator_out,
  output var  logic        external_capture_pin,
  output var  logic        serial_clock_line,
  output var  logic        timer_overflow_event,
  output var  logic        timer_compare_event,
  output var  logic        timer_capture_event,
  output var  logic [15:0] timer_count
);
  initial begin
    {comparator_out, external_capture_pin, serial_clock_line} = 3'h0;
    {timer_overflow_event, timer_compare_event, timer_capture_event} = 3'h0;
    timer_count = 16'h0000;
  end
  task pulse(input int k);
    @(posedge hclk);
    case (k)
      0: timer_overflow_event <= 1'b1;
      1: timer_compare_event <= 1'b1;
      default: timer_capture_event <= 1'b1;
    endcase
    @(posedge hclk);
    {timer_overflow_event, timer_compare_event, timer_capture_event} <= 3'h0;
  endtask : pulse
  task level(input int k, input logic v);
    @(posedge hclk);
    case (k)
      0: comparator_out <= v;
      1: external_capture_pin <= v;
      default: serial_clock_line <= v;
    endcase
  endtask : level
  task count(input logic [15:0] v);
    @(posedge hclk);
    timer_count <= v;
  endtask : count
endmodule : ssac_far_side
`default_nettype wire

// >>> single_slope_adc_control_bench.sv
// Self-checking bench for the converter control block.
// Assumes ssac_top, its bound checker and the far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module single_slope_adc_control_bench;
  localparam logic [31:0] CTL  = {24'h0, ssac_pkg::ANALOG_CONTROL_IDX, 2'b00};
  localparam logic [31:0] STAT = {24'h0, ssac_pkg::STATUS_IDX, 2'b00};
  localparam logic [31:0] CHN  = {24'h0, ssac_pkg::CHANNEL_IDX, 2'b00};
  localparam logic [31:0] REFS = {24'h0, ssac_pkg::REFERENCE_IDX, 2'b00};
  localparam logic [31:0] MISC = {24'h0, ssac_pkg::MISC_IDX, 2'b00};
  localparam logic [31:0] CAPH = {24'h0, ssac_pkg::CAPTURE_HIGH_IDX, 2'b00};
  localparam logic [31:0] CAPL = {24'h0, ssac_pkg::CAPTURE_LOW_IDX, 2'b00};
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        cmp_o, ext_pin, scl, ovf, cmpe, cape;
  logic [15:0] tcount;
  logic [7:0]  chan;
  logic        sup, bias, src, snk, cpow, ctrig, irq;
  int          fail_count, comparisons;
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  ssac_top #(.CHANNELS(8)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .comparator_out(cmp_o),
    .external_capture_pin(ext_pin), .serial_clock_line(scl), .timer_overflow_event(ovf),
    .timer_compare_event(cmpe), .timer_capture_event(cape), .timer_count(tcount),
    .channel_connect(chan), .supply_ref_connect(sup), .bias_ref_connect(bias),
    .ramp_source_on(src), .ramp_sink_on(snk), .comparator_power(cpow),
    .capture_trigger(ctrig), .comparator_irq(irq));
  ssac_far_side far (
    .hclk(hclk), .comparator_out(cmp_o), .external_capture_pin(ext_pin),
    .serial_clock_line(scl), .timer_overflow_event(ovf), .timer_compare_event(cmpe),
    .timer_capture_event(cape), .timer_count(tcount));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  // Address phase held until hready, then data phase until hready again
  task xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : xfer
  task wr(input logic [31:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask : wr
  task rd_chk(input logic [31:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(hrdata, {24'h0, exp});
  endtask : rd_chk
  task settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle
  task ramp_is(input logic [1:0] e);
    settle(3);
    chk({30'h0, src, snk}, {30'h0, e});
  endtask : ramp_is
  task results;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    results();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(CTL, 8'h00);
    chk({src, snk, cpow}, 3'h0);
    wr(CTL | 32'h100, 8'h81);
    rd_chk(CTL | 32'h100, 8'h00);
    rd_chk(CTL, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(CHN, 8'h01 << i);
      settle(3);
      chk(chan, 8'h01 << i);
    end
    wr(CHN, 8'h00);
    wr(REFS, 8'h02);
    settle(3);
    chk({chan, sup, bias}, {8'h00, 2'b10});
    wr(REFS, 8'h01);
    settle(3);
    chk({chan, sup, bias}, {8'h00, 2'b01});
    wr(CHN, 8'hA5);
    settle(3);
    chk({chan, sup, bias}, {8'hA5, 2'b00});
    $display("test switches done");
    wr(CTL, 8'h81);
    ramp_is(2'b10);
    rd_chk(CTL, 8'h81);
    wr(CTL, 8'h01);
    ramp_is(2'b01);
    wr(CTL, 8'h82);
    ramp_is(2'b00);
    chk(cpow, 1'b1);
    rd_chk(CTL, 8'h02);
    wr(CTL, 8'hA1);
    ramp_is(2'b10);
    far.level(0, 1'b1);
    settle(6);
    chk({src, snk}, 2'b01);
    rd_chk(CTL, 8'h21);
    far.level(0, 1'b0);
    wr(STAT, 8'h40);
    $display("test manual done");
    for (int m = 2; m < 4; m++) begin
      wr(CTL, (m == 2) ? 8'h41 : 8'h61);
      ramp_is(2'b01);
      rd_chk(CTL, (m == 2) ? 8'h51 : 8'h71);
      far.pulse((m == 2) ? 1 : 0);
      ramp_is(2'b01);
      far.pulse((m == 2) ? 0 : 1);
      ramp_is(2'b10);
      far.pulse(2);
      ramp_is(2'b01);
    end
    wr(CTL, 8'h40);
    far.pulse(0);
    ramp_is(2'b00);
    $display("test timer modes done");
    wr(CTL, 8'h18);
    far.count(16'h1234);
    far.level(0, 1'b1);
    settle(6);
    chk(irq, 1'b1);
    chk(ctrig, 1'b1);
    far.level(0, 1'b0);
    settle(6);
    rd_chk(STAT, 8'h80);
    rd_chk(CAPH, 8'h12);
    rd_chk(CAPL, 8'h34);
    wr(STAT, 8'h40);
    rd_chk(STAT, 8'h00);
    wr(CTL, 8'h10);
    far.level(0, 1'b1);
    settle(6);
    chk(irq, 1'b0);
    far.level(0, 1'b0);
    wr(STAT, 8'h40);
    $display("test flag done");
    wr(CTL, 8'h00);
    far.level(1, 1'b1);
    settle(6);
    chk(ctrig, 1'b1);
    far.level(1, 1'b0);
    wr(MISC, 8'h04);
    far.level(2, 1'b1);
    settle(6);
    chk(ctrig, 1'b1);
    far.level(2, 1'b0);
    settle(6);
    chk(ctrig, 1'b0);
    $display("test routing done");
    results();
  end
endmodule : single_slope_adc_control_bench
`default_nettype wire
